/* inc/scls_pkg.sv */
// package: register map, field positions, timing constants for strap capture block
package scls_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [11:0] LINK_CAP_ADDR = 12'h074;
  localparam logic [11:0] DEBUG_CTRL_ADDR = 12'h1DC;
  localparam logic [11:0] PORT_CFG_ADDR = 12'h574;
  localparam logic [11:0] STATUS_ADDR = 12'h600;
  localparam logic [11:0] EE_DATA_ADDR = 12'h604;
  localparam logic [11:0] EE_CMD_ADDR = 12'h608;
  // ==========================================================
  // link capability fields
  localparam int LC_SPEED_LSB = 0;
  localparam int LC_ASPM_AUTO_BIT = 4;
  localparam logic [3:0] LC_SPEED_GEN2 = 4'h2;
  // ==========================================================
  // debug control fields
  localparam int DC_LEGACY_BIT = 0;
  localparam int DC_RC_BIT = 1;
  localparam int DC_SSC_N_BIT = 2;
  localparam int DC_FALLBACK_N_BIT = 4;
  localparam int DC_CLKCFG_LSB = 8;
  localparam int DC_LED_SEL_BIT = 22;
  // ==========================================================
  // port configuration fields
  localparam int PC_DOWNSTREAM_BIT = 0;
  localparam int PC_ADV_REGS_BIT = 1;
  localparam int PC_SSC_CENTER_BIT = 2;
  localparam int PC_CLKMODE_LSB = 4;
  // ==========================================================
  // clock configuration patterns (H=1, L=0, msb first)
  localparam logic [3:0] CLKCFG_DUAL = 4'h8;
  localparam logic [3:0] CLKCFG_XTAL_ONLY = 4'h9;
  // ==========================================================
  // clock mode encodings in the port configuration field
  localparam logic [1:0] CLKMODE_DUAL = 2'h1;
  localparam logic [1:0] CLKMODE_XTAL = 2'h2;
  localparam logic [1:0] CLKMODE_TEST = 2'h0;
  // ==========================================================
  // led timing
  localparam int CLK_HZ = 50000000;
  localparam int LED_HALF_MS = 500;
  localparam int LED_HALF_CYCLES = CLK_HZ / 1000 * LED_HALF_MS;
  // ==========================================================
  // ltssm states
  typedef enum logic [1:0] {LT_DETECT, LT_CONFIG, LT_UP} scls_lt_state_t;
endpackage : scls_pkg

/* src/scls_blink.sv */
// blink divider: toggles output every half period of cycles
`timescale 1ns/1ps
module scls_blink #(
  parameter int HALF_CYCLES = 25000000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic run,
  // output
  output logic blink_q
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  logic [CW-1:0] cnt_q;

  initial begin
    if (HALF_CYCLES < 2) $error("HALF_CYCLES too small");
  end

  // ==========================================================
  // counter and toggle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (cnt_q == CW'(HALF_CYCLES - 1)) begin
      cnt_q <= '0;
      blink_q <= ~blink_q;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule // scls_blink

/* src/scls_top.sv */
// strap capture, configuration registers, lane led and wake/beacon forwarding
// Operation
// - on fundamental reset release, sample strap inputs and configure from them.
// - while fundamental reset is low, all logic except the bus slave and wake/beacon forwarding holds default state.
// - captured straps recorded in debug control and port configuration; link capability loads fixed values.
// - eeprom loader writes may replace captured values in those registers.
// - legacy strap high selects compatible register set; low selects advanced.
// - root complex strap high: root complex, lane is downstream port.
// - root complex strap low: endpoint adapter, interface is upstream port.
// - center-spread strap low enables center-spread clock tolerance on usb.
// - pattern HLLL: pcie from ref input, buffer ref out, usb from crystal.
// - pattern HLLH: everything from crystal, ref outputs synthesized.
// - fallback strap high: always advertise 5.0 GT/s and autonomous change.
// - fallback low: after config failure next detect exit advertises 2.5 GT/s only.
// - continued failures alternate gen1 and gen2 advertisement per detect exit.
// - lane pin is general io zero unless debug bit 22 selects lane status.
// - led off when disabled, on at 5.0 GT/s, blinks 0.5 s at 2.5 GT/s.
// - in d3cold, as root complex (downstream port), received beacon pulls wake low; the logic does so only while fundamental reset is high.
// - in d3cold, external wake low sends beacon toward root complex.
`timescale 1ns/1ps
module scls_top #(
  parameter int LED_HALF_CYCLES = scls_pkg::LED_HALF_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fundamental_reset_n,
  input wire logic power_on_reset_n,
  // straps
  input wire logic legacy_compat_select,
  input wire logic root_complex_select,
  input wire logic center_spread_support_n,
  input wire logic [3:0] clock_config_select,
  input wire logic rate_fallback_enable_n,
  // avalon-mm slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // link state
  input wire logic lane_enabled,
  input wire logic link_gen2,
  input wire logic train_config_fail,
  input wire logic detect_exit,
  input wire logic d3cold,
  input wire logic beacon_rx,
  // gpio controller side
  input wire logic general_io_zero_out,
  input wire logic general_io_zero_oe,
  // lane status pin
  input wire logic lane_pin_in,
  output logic lane_pin_out,
  output logic lane_pin_oe,
  output logic general_io_zero_in,
  // wake pin (open drain)
  input wire logic wake_in,
  output logic wake_out,
  output logic wake_oe,
  output logic beacon_tx,
  // configuration outputs
  output logic downstream_port,
  output logic advanced_regs,
  output logic ssc_center_en,
  output logic ref_out_buffered,
  output logic ref_out_synth,
  output logic pcie_from_xtal,
  output logic adv_gen2,
  output logic adv_auto_change
);
  logic cfg_rst;
  logic perst_q;
  logic cap_pend_q;
  logic [31:0] link_cap_q;
  logic [31:0] dbg_ctrl_q;
  logic [31:0] port_cfg_q;
  logic [31:0] ee_data_q;
  logic ack_q;
  logic fallback_alt_q;
  logic fail_seen_q;
  logic blink;
  logic led_n_d;
  logic [1:0] clkmode;
  scls_pkg::scls_lt_state_t lt_q;

  initial begin
    if (LED_HALF_CYCLES < 2) $error("LED_HALF_CYCLES too small");
  end

  // logic reset covers both the bus reset and the fundamental reset pin
  assign cfg_rst = rst | ~fundamental_reset_n;

  // ==========================================================
  // strap capture one cycle after reset release
  // straps are caught by clock, never loaded under async reset
  always_ff @(posedge clk_sys or posedge cfg_rst) begin
    if (cfg_rst) begin
      cap_pend_q <= 1'b1;
    end else begin
      cap_pend_q <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic wr_lc;
  logic wr_dc;
  logic wr_pc;
  logic wr_ee;
  logic ee_cmd;
  // writes land on the answer edge, the one where waitrequest is seen low
  assign wr_lc = avs_write && ack_q && avs_address == scls_pkg::LINK_CAP_ADDR;
  assign wr_dc = avs_write && ack_q && avs_address == scls_pkg::DEBUG_CTRL_ADDR;
  assign wr_pc = avs_write && ack_q && avs_address == scls_pkg::PORT_CFG_ADDR;
  assign wr_ee = avs_write && ack_q && avs_address == scls_pkg::EE_DATA_ADDR;
  assign ee_cmd = avs_write && ack_q && avs_address == scls_pkg::EE_CMD_ADDR;

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk_sys or posedge cfg_rst) begin
    if (cfg_rst) begin
      link_cap_q <= 32'h0000_0000;
      dbg_ctrl_q <= 32'h0000_0000;
      port_cfg_q <= 32'h0000_0000;
    end else if (cap_pend_q) begin
      link_cap_q <= 32'h0000_0000;
      link_cap_q[scls_pkg::LC_SPEED_LSB +: 4] <= scls_pkg::LC_SPEED_GEN2;
      link_cap_q[scls_pkg::LC_ASPM_AUTO_BIT] <= 1'b1;
      dbg_ctrl_q <= 32'h0000_0000;
      dbg_ctrl_q[scls_pkg::DC_LEGACY_BIT] <= legacy_compat_select;
      dbg_ctrl_q[scls_pkg::DC_RC_BIT] <= root_complex_select;
      dbg_ctrl_q[scls_pkg::DC_SSC_N_BIT] <= center_spread_support_n;
      dbg_ctrl_q[scls_pkg::DC_FALLBACK_N_BIT] <= rate_fallback_enable_n;
      dbg_ctrl_q[scls_pkg::DC_CLKCFG_LSB +: 4] <= clock_config_select;
      port_cfg_q <= 32'h0000_0000;
      port_cfg_q[scls_pkg::PC_DOWNSTREAM_BIT] <= root_complex_select;
      port_cfg_q[scls_pkg::PC_ADV_REGS_BIT] <= ~legacy_compat_select;
      port_cfg_q[scls_pkg::PC_SSC_CENTER_BIT] <= ~center_spread_support_n;
      port_cfg_q[scls_pkg::PC_CLKMODE_LSB +: 2] <=
        (clock_config_select == scls_pkg::CLKCFG_DUAL) ? scls_pkg::CLKMODE_DUAL :
        (clock_config_select == scls_pkg::CLKCFG_XTAL_ONLY) ? scls_pkg::CLKMODE_XTAL :
        scls_pkg::CLKMODE_TEST;
    end else begin
      // loader replaces captured values over the bus
      if (wr_lc) begin
        link_cap_q <= merge(link_cap_q, avs_writedata, avs_byteenable);
      end
      if (wr_dc) begin
        dbg_ctrl_q <= merge(dbg_ctrl_q, avs_writedata, avs_byteenable);
      end
      if (wr_pc) begin
        port_cfg_q <= merge(port_cfg_q, avs_writedata, avs_byteenable);
      end
    end
  end

  // scratch data word used by loader sequencing
  always_ff @(posedge clk_sys or posedge cfg_rst) begin
    if (cfg_rst) begin
      ee_data_q <= 32'h0000_0000;
    end else if (wr_ee) begin
      ee_data_q <= merge(ee_data_q, avs_writedata, avs_byteenable);
    end else if (ee_cmd) begin
      ee_data_q <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // avalon slave: one wait cycle, answer on the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
      if (avs_read && !ack_q) begin
        unique case (avs_address)
          scls_pkg::LINK_CAP_ADDR: avs_readdata <= link_cap_q;
          scls_pkg::DEBUG_CTRL_ADDR: avs_readdata <= dbg_ctrl_q;
          scls_pkg::PORT_CFG_ADDR: avs_readdata <= port_cfg_q;
          scls_pkg::STATUS_ADDR: avs_readdata <= {26'h0, fail_seen_q, fallback_alt_q,
                                                  d3cold, link_gen2, lane_enabled, ~cap_pend_q};
          scls_pkg::EE_DATA_ADDR: avs_readdata <= ee_data_q;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ==========================================================
  // clock configuration decode
  assign clkmode = port_cfg_q[scls_pkg::PC_CLKMODE_LSB +: 2];
  always_ff @(posedge clk_sys or posedge cfg_rst) begin
    if (cfg_rst) begin
      downstream_port <= 1'b0;
      advanced_regs <= 1'b0;
      ssc_center_en <= 1'b0;
      ref_out_buffered <= 1'b0;
      ref_out_synth <= 1'b0;
      pcie_from_xtal <= 1'b0;
    end else begin
      downstream_port <= port_cfg_q[scls_pkg::PC_DOWNSTREAM_BIT];
      advanced_regs <= port_cfg_q[scls_pkg::PC_ADV_REGS_BIT];
      ssc_center_en <= port_cfg_q[scls_pkg::PC_SSC_CENTER_BIT];
      ref_out_buffered <= clkmode == scls_pkg::CLKMODE_DUAL;
      ref_out_synth <= clkmode == scls_pkg::CLKMODE_XTAL;
      pcie_from_xtal <= clkmode == scls_pkg::CLKMODE_XTAL;
    end
  end

  // ==========================================================
  // rate fallback advertisement
  // the fallback bit is assumed static at runtime, so no resync of the toggle is done
  always_ff @(posedge clk_sys or posedge cfg_rst) begin
    if (cfg_rst) begin
      lt_q <= scls_pkg::LT_DETECT;
      fail_seen_q <= 1'b0;
      fallback_alt_q <= 1'b0;
    end else begin
      unique case (lt_q)
        scls_pkg::LT_DETECT: begin
          if (detect_exit) begin
            lt_q <= scls_pkg::LT_CONFIG;
            if (dbg_ctrl_q[scls_pkg::DC_FALLBACK_N_BIT]) begin
              fallback_alt_q <= 1'b0;
            end else if (fail_seen_q) begin
              fallback_alt_q <= ~fallback_alt_q;
              fail_seen_q <= 1'b0;
            end
          end
        end
        scls_pkg::LT_CONFIG: begin
          if (train_config_fail) begin
            lt_q <= scls_pkg::LT_DETECT;
            fail_seen_q <= 1'b1;
          end else if (lane_enabled) begin
            lt_q <= scls_pkg::LT_UP;
          end
        end
        scls_pkg::LT_UP: begin
          if (!lane_enabled) begin
            lt_q <= scls_pkg::LT_DETECT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge cfg_rst) begin
    if (cfg_rst) begin
      adv_gen2 <= 1'b1;
      adv_auto_change <= 1'b1;
    end else begin
      adv_gen2 <= ~fallback_alt_q;
      adv_auto_change <= ~fallback_alt_q;
    end
  end

  // ==========================================================
  // lane status led
  scls_blink #(
    .HALF_CYCLES(LED_HALF_CYCLES)
  ) u_blink (
    .clk_sys(clk_sys),
    .rst(cfg_rst),
    .run(lane_enabled & ~link_gen2),
    .blink_q(blink)
  );

  // active-low: 0 lights the led
  always_comb begin
    if (!lane_enabled) begin
      led_n_d = 1'b1;
    end else if (link_gen2) begin
      led_n_d = 1'b0;
    end else begin
      led_n_d = blink;
    end
  end

  always_ff @(posedge clk_sys or posedge cfg_rst) begin
    if (cfg_rst) begin
      lane_pin_out <= 1'b0;
      lane_pin_oe <= 1'b0;
      general_io_zero_in <= 1'b0;
    end else if (dbg_ctrl_q[scls_pkg::DC_LED_SEL_BIT]) begin
      lane_pin_out <= led_n_d;
      lane_pin_oe <= 1'b1;
      general_io_zero_in <= 1'b0;
    end else begin
      lane_pin_out <= general_io_zero_out;
      lane_pin_oe <= general_io_zero_oe;
      general_io_zero_in <= lane_pin_in;
    end
  end

  // ==========================================================
  // wake and beacon forwarding; power_on_reset_n keeps this alive in d3cold
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      perst_q <= 1'b0;
      wake_out <= 1'b0;
      wake_oe <= 1'b0;
      beacon_tx <= 1'b0;
    end else begin
      perst_q <= power_on_reset_n;
      wake_out <= 1'b0;
      wake_oe <= perst_q & d3cold & beacon_rx & downstream_port;
      beacon_tx <= perst_q & d3cold & ~wake_in & ~wake_oe & ~downstream_port;
    end
  end
endmodule // scls_top

/* bench/scls_checker.sv */
// checker: bus handshake, strap capture, fallback and wake timing
`timescale 1ns/1ps
module scls_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fundamental_reset_n,
  input wire logic power_on_reset_n,
  // straps
  input wire logic root_complex_select,
  input wire logic [3:0] clock_config_select,
  input wire logic rate_fallback_enable_n,
  // bus
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // link and outputs
  input wire logic train_config_fail,
  input wire logic detect_exit,
  input wire logic d3cold,
  input wire logic beacon_rx,
  input wire logic wake_oe,
  input wire logic downstream_port,
  input wire logic ref_out_buffered,
  input wire logic adv_gen2
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_cap; $rose(fundamental_reset_n) ##1 fundamental_reset_n [*2]; endsequence
  property p_wait; s_req |-> ##[1:2] !avs_waitrequest; endproperty
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_unmap; !avs_waitrequest && avs_read && !(avs_address inside {12'h074, 12'h1DC, 12'h574,
    12'h600, 12'h604, 12'h608}) |-> avs_readdata == 32'h0; endproperty
  property p_freset; !fundamental_reset_n |=> !downstream_port && adv_gen2 && avs_waitrequest; endproperty
  property p_decode; s_cap |-> downstream_port == root_complex_select &&
    ref_out_buffered == (clock_config_select == 4'h8); endproperty
  property p_fboff; rate_fallback_enable_n |-> adv_gen2; endproperty
  property p_toggle; !rate_fallback_enable_n && detect_exit && $past(train_config_fail) |->
    ##2 adv_gen2 != $past(adv_gen2, 2); endproperty
  property p_wake; (d3cold && beacon_rx && downstream_port && power_on_reset_n) [*3] |-> wake_oe; endproperty
  a_wait: assert property (p_wait) else $error("request not answered");
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_freset: assert property (p_freset) else $error("state not held in reset");
  a_decode: assert property (p_decode) else $error("strap decode wrong");
  a_fboff: assert property (p_fboff) else $error("gen2 not advertised");
  a_toggle: assert property (p_toggle) else $error("advertisement not toggled");
  a_wake: assert property (p_wake) else $error("wake not pulled");
endmodule // scls_checker
bind scls_top scls_checker u_chk (.*);

/* bench/scls_board.sv */
// board model: strap resistors and pulled-up wake line
`timescale 1ns/1ps
module scls_board (
  // control
  input wire logic fundamental_reset_n,
  input wire logic [7:0] strap_word,
  input wire logic ext_wake_low,
  // strap pins
  output logic legacy_compat_select,
  output logic root_complex_select,
  output logic center_spread_support_n,
  output logic [3:0] clock_config_select,
  output logic rate_fallback_enable_n,
  // wake line
  input wire logic wake_oe,
  output logic wake_in
);
  // ==========================================================
  // straps move only while the device is held in reset
  always_latch begin
    if (!fundamental_reset_n) begin
      {legacy_compat_select, root_complex_select} <= strap_word[7:6];
      {center_spread_support_n, rate_fallback_enable_n} <= strap_word[5:4];
      // factory patterns never reach the pins
      clock_config_select <= (strap_word[3:0] == scls_pkg::CLKCFG_XTAL_ONLY) ?
        scls_pkg::CLKCFG_XTAL_ONLY : scls_pkg::CLKCFG_DUAL;
    end
  end
  // open drain, pull-up
  assign wake_in = !(wake_oe || ext_wake_low);
endmodule // scls_board

/* bench/tb_top.sv */
// testbench: strap capture, register access, led, fallback and wake
`timescale 1ns/1ps
module tb_top;
  localparam int HALF = 10;
  logic clk_sys, rst, fundamental_reset_n, power_on_reset_n, b;
  logic legacy_compat_select, root_complex_select, center_spread_support_n, rate_fallback_enable_n;
  logic [3:0] clock_config_select, avs_byteenable;
  logic [11:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic lane_enabled, link_gen2, train_config_fail, detect_exit, d3cold, beacon_rx;
  logic general_io_zero_out, general_io_zero_oe, lane_pin_in, lane_pin_out, lane_pin_oe, general_io_zero_in;
  logic wake_in, wake_out, wake_oe, beacon_tx, ext_wake_low;
  logic downstream_port, advanced_regs, ssc_center_en, ref_out_buffered, ref_out_synth, pcie_from_xtal;
  logic adv_gen2, adv_auto_change;
  logic [7:0] strap_word, w;
  logic [7:0] words [4] = '{8'hD8, 8'h39, 8'hA8, 8'h49};
  int miscompares = 0;
  int num_checks = 0;
  int n;
  scls_top #(.LED_HALF_CYCLES(HALF)) u_dut (.*);
  scls_board u_board (.*);
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // request held until the edge that samples waitrequest low; read data taken there
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic boot(input logic [7:0] sw);
    @(posedge clk_sys);
    fundamental_reset_n <= 1'b0;
    power_on_reset_n <= 1'b0;
    strap_word <= sw;
    repeat (3) @(posedge clk_sys);
    check({31'h0, adv_gen2 & !downstream_port & avs_waitrequest}, 32'h1);
    fundamental_reset_n <= 1'b1;
    power_on_reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  // enter configuration, fail there, then leave detect again
  task automatic fail_detect();
    @(posedge clk_sys);
    detect_exit <= 1'b1;
    @(posedge clk_sys);
    detect_exit <= 1'b0;
    train_config_fail <= 1'b1;
    @(posedge clk_sys);
    train_config_fail <= 1'b0;
    detect_exit <= 1'b1;
    @(posedge clk_sys);
    detect_exit <= 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end
  initial begin
    {rst, fundamental_reset_n, power_on_reset_n, ext_wake_low} = 4'h8;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {46'h0, 4'hF};
    {lane_enabled, link_gen2, train_config_fail, detect_exit, d3cold, beacon_rx} = 6'h0;
    {general_io_zero_out, general_io_zero_oe, lane_pin_in, strap_word} = {3'h0, 8'hD8};
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (words[i]) begin
      w = words[i];
      boot(w);
      rdchk(12'h1DC, {20'h0, w[3:0], 3'h0, w[4], 1'b0, w[5], w[6], w[7]});
      rdchk(12'h574, {26'h0, w[0] ? 2'h2 : 2'h1, 1'b0, !w[5], !w[7], w[6]});
      rdchk(12'h074, 32'h12);
      check({26'h0, downstream_port, advanced_regs, ssc_center_en, ref_out_buffered, ref_out_synth, pcie_from_xtal},
        {26'h0, w[6], !w[7], !w[5], !w[0], w[0], w[0]});
    end
    bus(1'b1, 12'h700, 32'h5);
    rdchk(12'h700, 32'h0);
    rdchk(12'h600, 32'h1);
    bus(1'b1, 12'h604, 32'h000000A5);
    rdchk(12'h604, 32'h000000A5);
    bus(1'b1, 12'h608, 32'h0);
    rdchk(12'h604, 32'h0);
    boot(8'hD8);
    general_io_zero_out <= 1'b1;
    general_io_zero_oe <= 1'b1;
    lane_pin_in <= 1'b1;
    repeat (3) @(negedge clk_sys);
    check({29'h0, lane_pin_out, lane_pin_oe, general_io_zero_in}, 32'h7);
    bus(1'b1, 12'h1DC, 32'h00400813);
    rdchk(12'h1DC, 32'h00400813);
    repeat (3) @(negedge clk_sys);
    check({31'h0, lane_pin_out}, 32'h1);
    @(posedge clk_sys);
    {lane_enabled, link_gen2} <= 2'h3;
    repeat (3) @(negedge clk_sys);
    check({31'h0, lane_pin_out}, 32'h0);
    @(posedge clk_sys);
    link_gen2 <= 1'b0;
    repeat (3) @(negedge clk_sys);
    for (int k = 0; k < 2; k++) begin
      b = lane_pin_out;
      n = 0;
      while (lane_pin_out === b && n < 40) begin
        @(negedge clk_sys);
        n++;
      end
    end
    check(n, HALF);
    fail_detect();
    check({30'h0, adv_gen2, adv_auto_change}, 32'h3);
    @(posedge clk_sys);
    {d3cold, beacon_rx} <= 2'h3;
    repeat (5) @(negedge clk_sys);
    check({28'h0, wake_oe, wake_in, wake_out, beacon_tx}, 32'h8);
    @(posedge clk_sys);
    {d3cold, beacon_rx, lane_enabled} <= 3'h0;
    boot(8'hA8);
    fail_detect();
    check({30'h0, adv_gen2, adv_auto_change}, 32'h0);
    fail_detect();
    check({30'h0, adv_gen2, adv_auto_change}, 32'h3);
    @(posedge clk_sys);
    {d3cold, ext_wake_low} <= 2'h3;
    repeat (5) @(negedge clk_sys);
    check({30'h0, beacon_tx, wake_oe}, 32'h2);
    stop_test();
  end
endmodule // tb_top
